// ===== host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  // bus clock
  input wire logic ref_clk_i,
  // register port
  output var uart_ctl_pkg::host_req_t host_o,
  input wire logic [7:0] rdata_i
);
  import uart_ctl_pkg::*;

  // ****
  // bus cycles
  // ****
  initial host_o = '0;

  // strobe held over the taking edge, address and data scrambled once released
  task automatic access(input logic rd, input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    host_o = '{cs: 1'b1, rd: rd, wr: !rd, addr: a, wdata: d};
    @(negedge ref_clk_i);
    host_o = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    access(1'b0, a, d);
  endtask

  // read data stands from the edge after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    access(1'b1, a, 8'h00);
    @(negedge ref_clk_i);
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== irq_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none
module irq_prio_enc (
  // pending sources, index 0 is highest priority
  input wire logic [6:0] pend_i,
  // winning source
  output var uart_ctl_pkg::src_t src_o
);
  import uart_ctl_pkg::*;
  assign src_o = pend_i[0] ? SRC_LSR :
                 pend_i[1] ? SRC_RXTO :
                 pend_i[2] ? SRC_RX_READY_PIN_N :
                 pend_i[3] ? SRC_TX_READY_PIN_N :
                 pend_i[4] ? SRC_MSR :
                 pend_i[5] ? SRC_XSPEC :
                 pend_i[6] ? SRC_FLOW : SRC_NONE;
endmodule
`default_nettype wire

// ===== rx_timeout_timer.sv
`timescale 1ns/1ps
`default_nettype none
module rx_timeout_timer #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic bit_tick_i,
  input wire logic restart_i,
  input wire logic armed_i,
  input wire logic [CNT_W-1:0] limit_i,
  // expiry pulse
  output logic expire_o
);
  logic [CNT_W-1:0] cnt_q;
  logic fired_q;
  wire logic [CNT_W-1:0] cnt_inc = cnt_q + 1'b1;
  wire logic hit = armed_i && !restart_i && !fired_q && bit_tick_i && (cnt_inc == limit_i);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || restart_i || !armed_i)
    begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      expire_o <= 1'b0;
    end
    else
    begin
      if (bit_tick_i && !fired_q)
        cnt_q <= cnt_inc;
      fired_q <= fired_q | hit;
      expire_o <= hit;
    end
  end
endmodule
`default_nettype wire

// ===== uart_ctl_params.svh
`ifndef UART_CTL_PARAMS_SVH
`define UART_CTL_PARAMS_SVH

// ****************
// register offsets
// ****************
`define OFS_DATA 3'h0
`define OFS_IER 3'h1
`define OFS_ISR 3'h2
`define OFS_LCR 3'h3
`define OFS_LSR 3'h5
`define OFS_MSR 3'h6
`define LCR_EFR_KEY 8'hBF

// ****************
// field positions
// ****************
`define IER_RX_READY_PIN_N 0
`define IER_TX_READY_PIN_N 1
`define IER_LSR 2
`define IER_MSR 3
`define IER_XOFF 5
`define IER_RTS 6
`define IER_CTS 7
`define EFR_ENH 4
`define EFR_ARTS 6
`define EFR_ACTS 7
`define FCR_EN 0
`define FCR_RXRST 1
`define FCR_TXRST 2
`define FCR_DMA 3
`define LCR_STOP 2

// ****************
// reset values and codes
// ****************
`define REG_RST 8'h00
`define ISR_LSR 6'h06
`define ISR_RXTO 6'h0C
`define ISR_RX_READY_PIN_N 6'h04
`define ISR_TX_READY_PIN_N 6'h02
`define ISR_MSR 6'h00
`define ISR_XSPEC 6'h10
`define ISR_FLOW 6'h20
`define ISR_NONE 6'h01

// ****************
// levels and timing
// ****************
`define TXTRIG_0 6'h10
`define TXTRIG_1 6'h08
`define TXTRIG_2 6'h18
`define TXTRIG_3 6'h1E
`define RXTRIG_0 6'h08
`define RXTRIG_1 6'h10
`define RXTRIG_2 6'h18
`define RXTRIG_3 6'h1E
`define TRIG_NOFIFO 6'h01
`define FIFO_DEPTH 6'h20
`define LEN_BASE 5'h07
`define TO_BITS 7'h0C

`endif

// ===== uart_ctl_pkg.sv
`default_nettype none
package uart_ctl_pkg;

  typedef enum logic [7:0] {
    SRC_NONE  = 8'h01,
    SRC_LSR   = 8'h02,
    SRC_RXTO  = 8'h04,
    SRC_RX_READY_PIN_N = 8'h08,
    SRC_TX_READY_PIN_N = 8'h10,
    SRC_MSR   = 8'h20,
    SRC_XSPEC = 8'h40,
    SRC_FLOW  = 8'h80
  } src_t;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic fifo_en;
    logic dma_mode;
    logic rx_fifo_reset;
    logic tx_fifo_reset;
    logic [5:0] rx_trig;
    logic [5:0] tx_trig;
    logic [1:0] char_len;
    logic stop_sel;
  } ctl_t;

endpackage
`default_nettype wire

// ===== uart_irq_fifo_format_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_params.svh"
module uart_irq_fifo_format_ctl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // host register port
  input wire uart_ctl_pkg::host_req_t host_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  // datapath status
  input wire logic [5:0] rx_level_i,
  input wire logic [5:0] tx_level_i,
  input wire logic [7:0] rx_data_i,
  input wire logic [7:0] line_state_i,
  input wire logic [7:0] modem_state_i,
  input wire logic rx_char_i,
  input wire logic bit_tick_i,
  input wire logic xoff_match_i,
  input wire logic xon_match_i,
  input wire logic spec_match_i,
  // flow control pins
  input wire logic rts_pin_n_i,
  input wire logic cts_pin_n_i,
  // datapath control
  output var uart_ctl_pkg::ctl_t ctl_o,
  output logic rx_pop_o,
  output logic tx_push_o,
  output logic [7:0] tx_data_o,
  // dma pins
  output logic tx_ready_pin_n_o,
  output logic rx_ready_pin_n_o
);
  import uart_ctl_pkg::*;

  // ****************
  // register decode
  // ****************
  logic [7:0] ier_q;
  logic [7:0] efr_q;
  logic [7:0] lcr_q;
  src_t src_q;
  wire logic wr_go = host_i.cs && host_i.wr;
  wire logic rd_go = host_i.cs && host_i.rd;
  wire logic efr_sel = (lcr_q == `LCR_EFR_KEY);
  wire logic [7:0] wd = host_i.wdata;
  wire logic wr_thr = wr_go && host_i.addr == `OFS_DATA;
  wire logic wr_ier = wr_go && host_i.addr == `OFS_IER;
  wire logic wr_fcr = wr_go && host_i.addr == `OFS_ISR && !efr_sel;
  wire logic wr_efr = wr_go && host_i.addr == `OFS_ISR && efr_sel;
  wire logic wr_lcr = wr_go && host_i.addr == `OFS_LCR;
  wire logic rd_rhr = rd_go && host_i.addr == `OFS_DATA;
  wire logic rd_isr = rd_go && host_i.addr == `OFS_ISR && !efr_sel;
  wire logic rd_lsr = rd_go && host_i.addr == `OFS_LSR;
  wire logic rd_msr = rd_go && host_i.addr == `OFS_MSR;
  wire logic enh = efr_q[`EFR_ENH];

  // ****************
  // fifo setup and format
  // ****************
  ctl_t ctl_d;
  wire logic [5:0] tx_trig_sel = (wd[5:4] == 2'b00) ? `TXTRIG_0 :
                                 (wd[5:4] == 2'b01) ? `TXTRIG_1 :
                                 (wd[5:4] == 2'b10) ? `TXTRIG_2 : `TXTRIG_3;
  wire logic [5:0] rx_trig_sel = (wd[7:6] == 2'b00) ? `RXTRIG_0 :
                                 (wd[7:6] == 2'b01) ? `RXTRIG_1 :
                                 (wd[7:6] == 2'b10) ? `RXTRIG_2 : `RXTRIG_3;
  wire logic fcr_take = wr_fcr && wd[`FCR_EN];

  always_comb
  begin
    ctl_d = ctl_o;
    ctl_d.rx_fifo_reset = fcr_take && wd[`FCR_RXRST];
    ctl_d.tx_fifo_reset = fcr_take && wd[`FCR_TXRST];
    if (wr_fcr)
      ctl_d.fifo_en = wd[`FCR_EN];
    if (fcr_take)
    begin
      ctl_d.dma_mode = wd[`FCR_DMA];
      ctl_d.rx_trig = rx_trig_sel;
      if (enh)
        ctl_d.tx_trig = tx_trig_sel;
    end
    ctl_d.char_len = lcr_q[1:0];
    ctl_d.stop_sel = lcr_q[`LCR_STOP];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ier_q <= `REG_RST;
      efr_q <= `REG_RST;
      lcr_q <= `REG_RST;
      ctl_o <= '{rx_trig: `RXTRIG_0, tx_trig: `TXTRIG_0, default: '0};
    end
    else
    begin
      if (wr_ier)
        ier_q <= {enh ? wd[7:4] : ier_q[7:4], wd[3:0]};
      if (wr_efr)
        efr_q <= wd;
      if (wr_lcr)
        lcr_q <= wd;
      ctl_o <= ctl_d;
    end
  end

  // ****************
  // effective levels
  // ****************
  wire logic [5:0] rx_trig_eff = ctl_o.fifo_en ? ctl_o.rx_trig : `TRIG_NOFIFO;
  wire logic [5:0] tx_trig_eff = ctl_o.fifo_en ? ctl_o.tx_trig : `TRIG_NOFIFO;
  wire logic rx_at_trig = (rx_level_i >= rx_trig_eff);
  wire logic tx_below = (tx_level_i < tx_trig_eff);
  wire logic tx_empty = (tx_level_i == 6'h00);

  // ****************
  // rx timeout timer
  // ****************
  wire logic [4:0] char_bits = `LEN_BASE + {3'b000, lcr_q[1:0]} + {4'b0000, lcr_q[`LCR_STOP]};
  wire logic [6:0] to_limit = {char_bits, 2'b00} + `TO_BITS;
  wire logic to_armed = (rx_level_i != 6'h00);
  wire logic to_expire;

  rx_timeout_timer #(
    .CNT_W(7)
  ) i_rx_timeout_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .bit_tick_i(bit_tick_i),
    .restart_i(rx_char_i || rd_rhr),
    .armed_i(to_armed),
    .limit_i(to_limit),
    .expire_o(to_expire)
  );

  // ****************
  // interrupt sources
  // ****************
  logic lsr_pend_q, to_pend_q, rxr_pend_q, txr_pend_q, msr_pend_q;
  logic xoff_pend_q, spec_pend_q, flow_pend_q;
  logic line_err_q, modem_chg_q, rts_n_q, cts_n_q;
  logic tx_below_q, tx_empty_q, tx_over_q;
  wire logic line_err = |line_state_i[4:1];
  wire logic modem_chg = |modem_state_i[3:0];
  wire logic line_rise = ier_q[`IER_LSR] && line_err && !line_err_q;
  wire logic modem_rise = ier_q[`IER_MSR] && modem_chg && !modem_chg_q;
  wire logic rts_rise = enh && efr_q[`EFR_ARTS] && ier_q[`IER_RTS] && rts_pin_n_i && !rts_n_q;
  wire logic cts_rise = enh && efr_q[`EFR_ACTS] && ier_q[`IER_CTS] && cts_pin_n_i && !cts_n_q;
  wire logic to_set = ier_q[`IER_RX_READY_PIN_N] && to_expire;
  wire logic tx_fall = tx_below && !tx_below_q;
  wire logic tx_drain = tx_empty && !tx_empty_q && !tx_over_q;
  wire logic tx_arm = wr_ier && wd[`IER_TX_READY_PIN_N] && !ier_q[`IER_TX_READY_PIN_N] && tx_empty;
  wire logic tx_set = (ier_q[`IER_TX_READY_PIN_N] && (tx_fall || tx_drain)) || tx_arm;
  wire logic xoff_set = enh && ier_q[`IER_XOFF] && xoff_match_i;
  wire logic spec_set = enh && ier_q[`IER_XOFF] && spec_match_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      {line_err_q, modem_chg_q, rts_n_q, cts_n_q} <= 4'h0;
      {tx_below_q, tx_empty_q, tx_over_q} <= 3'h0;
      {lsr_pend_q, to_pend_q, rxr_pend_q, txr_pend_q} <= 4'h0;
      {msr_pend_q, xoff_pend_q, spec_pend_q, flow_pend_q} <= 4'h0;
    end
    else
    begin
      {line_err_q, modem_chg_q, rts_n_q, cts_n_q} <= {line_err, modem_chg, rts_pin_n_i, cts_pin_n_i};
      tx_below_q <= tx_below;
      tx_empty_q <= tx_empty;
      tx_over_q <= (tx_level_i > tx_trig_eff) || (tx_over_q && !tx_empty);
      lsr_pend_q <= line_rise || (lsr_pend_q && !rd_lsr);
      to_pend_q <= to_set || (to_pend_q && !rd_rhr);
      rxr_pend_q <= ier_q[`IER_RX_READY_PIN_N] && rx_at_trig;
      txr_pend_q <= tx_set || (txr_pend_q && !rd_isr && !wr_thr);
      msr_pend_q <= modem_rise || (msr_pend_q && !rd_msr);
      xoff_pend_q <= xoff_set || (xoff_pend_q && !rd_isr && !xon_match_i);
      spec_pend_q <= spec_set || (spec_pend_q && !rd_isr && !rx_char_i);
      flow_pend_q <= rts_rise || cts_rise || (flow_pend_q && !rd_msr);
    end
  end

  // ****************
  // priority and hold
  // ****************
  wire logic [6:0] pend = {flow_pend_q & enh, (xoff_pend_q | spec_pend_q) & enh, msr_pend_q,
                           txr_pend_q, rxr_pend_q, to_pend_q, lsr_pend_q};
  src_t enc_src;
  src_t src_d;
  logic [5:0] isr_code;
  wire logic cur_live = |(pend & src_q[7:1]);

  irq_prio_enc i_irq_prio_enc (
    .pend_i(pend),
    .src_o(enc_src)
  );

  assign src_d = cur_live ? src_q : enc_src;

  always_comb
  begin
    case (src_q)
      SRC_LSR: isr_code = `ISR_LSR;
      SRC_RXTO: isr_code = `ISR_RXTO;
      SRC_RX_READY_PIN_N: isr_code = `ISR_RX_READY_PIN_N;
      SRC_TX_READY_PIN_N: isr_code = `ISR_TX_READY_PIN_N;
      SRC_MSR: isr_code = `ISR_MSR;
      SRC_XSPEC: isr_code = `ISR_XSPEC;
      SRC_FLOW: isr_code = `ISR_FLOW;
      default: isr_code = `ISR_NONE;
    endcase
  end

  // ****************
  // read data and pins
  // ****************
  wire logic [7:0] isr_val = {{2{ctl_o.fifo_en}}, isr_code};
  wire logic [7:0] rd_mux = (host_i.addr == `OFS_DATA) ? rx_data_i :
                            (host_i.addr == `OFS_IER) ? ier_q :
                            (host_i.addr == `OFS_ISR) ? (efr_sel ? efr_q : isr_val) :
                            (host_i.addr == `OFS_LCR) ? lcr_q :
                            (host_i.addr == `OFS_LSR) ? line_state_i :
                            (host_i.addr == `OFS_MSR) ? modem_state_i : `REG_RST;
  wire logic rx_pin_act = ctl_o.dma_mode ? (rx_at_trig || to_pend_q) : to_armed;
  wire logic tx_pin_act = ctl_o.dma_mode ? (tx_level_i < `FIFO_DEPTH) : tx_empty;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      src_q <= SRC_NONE;
      irq_o <= 1'b0;
      rdata_o <= `REG_RST;
      {rx_pop_o, tx_push_o} <= 2'b00;
      tx_data_o <= `REG_RST;
      tx_ready_pin_n_o <= 1'b1;
      rx_ready_pin_n_o <= 1'b1;
    end
    else
    begin
      src_q <= src_d;
      irq_o <= (src_d != SRC_NONE);
      if (rd_go)
        rdata_o <= rd_mux;
      rx_pop_o <= rd_rhr;
      tx_push_o <= wr_thr;
      if (wr_thr)
        tx_data_o <= wd;
      tx_ready_pin_n_o <= !tx_pin_act;
      rx_ready_pin_n_o <= !rx_pin_act;
    end
  end

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_rts_irq;
    rts_rise && !flow_pend_q |=> flow_pend_q ##0 (src_q != SRC_NONE || pend[6]);
  endproperty
  a_rts_irq: assert property (p_rts_irq) else $error("rts rise lost");

  property p_cts_irq;
    cts_rise |=> flow_pend_q;
  endproperty
  a_cts_irq: assert property (p_cts_irq) else $error("cts rise lost");

  property p_hold;
    (src_q != SRC_NONE) && cur_live |=> src_q == $past(src_q);
  endproperty
  a_hold: assert property (p_hold) else $error("source changed while pending");

  property p_isr_idle;
    rd_isr && src_q == SRC_NONE |=> rdata_o[5:0] == `ISR_NONE && (irq_o == (src_q != SRC_NONE));
  endproperty
  a_isr_idle: assert property (p_isr_idle) else $error("idle code wrong");

  property p_isr_fifo;
    rd_isr |=> rdata_o[7:6] == {2{$past(ctl_o.fifo_en)}};
  endproperty
  a_isr_fifo: assert property (p_isr_fifo) else $error("fifo status bits wrong");

  property p_fcr_ignore;
    wr_fcr && !wd[`FCR_EN] |=> !ctl_o.fifo_en && $stable(ctl_o.rx_trig) && !ctl_o.rx_fifo_reset;
  endproperty
  a_fcr_ignore: assert property (p_fcr_ignore) else $error("setup write not ignored");

  property p_rx_reset;
    fcr_take && wd[`FCR_RXRST] |=> ctl_o.rx_fifo_reset ##1
      (!ctl_o.rx_fifo_reset || $past(fcr_take && wd[`FCR_RXRST]));
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("rx fifo reset pulse wrong");

  property p_tx_reset;
    fcr_take && wd[`FCR_TXRST] |=> ctl_o.tx_fifo_reset;
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("tx fifo reset missing");

  property p_thr_clear;
    wr_thr && !tx_set |=> !txr_pend_q;
  endproperty
  a_thr_clear: assert property (p_thr_clear) else $error("tx ready not cleared");

  property p_timeout;
    to_set |=> to_pend_q;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout lost");

  property p_len;
    wr_lcr |=> ##1 ctl_o.char_len == $past(wd[1:0], 2);
  endproperty
  a_len: assert property (p_len) else $error("char length wrong");

endmodule
`default_nettype wire

// ===== uart_irq_fifo_format_ctl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_params.svh"
module uart_irq_fifo_format_ctl_bench;
  import uart_ctl_pkg::*;

  typedef struct packed {
    logic [7:0] fifo_setup;
    logic [7:0] line_format;
    logic [7:0] rx;
    logic [7:0] tx;
  } row_t;

  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  host_req_t host;
  logic [7:0] rdata;
  logic irq;
  logic [5:0] rx_level = 6'h00;
  logic [5:0] tx_level = 6'h14;
  logic [7:0] line_state = 8'h00;
  logic [7:0] modem_state = 8'h00;
  logic [3:0] ev = 4'h0;
  logic tick_en = 1'b0;
  logic bit_tick = 1'b0;
  logic rts_n = 1'b0;
  logic cts_n = 1'b0;
  ctl_t ctl;
  logic rx_pop;
  logic tx_push;
  logic [7:0] tx_data;
  logic tx_pin_n;
  logic rx_pin_n;
  int n_pop = 0;
  int failures = 0;
  int num_checks = 0;
  int n_rxr = 0;
  int n_txr = 0;
  int ticks = 0;
  row_t rows [4] = '{'{8'h01, 8'h00, 8'h08, 8'h10}, '{8'h59, 8'h05, 8'h10, 8'h08},
                     '{8'hA1, 8'h06, 8'h18, 8'h18}, '{8'hF1, 8'h07, 8'h1E, 8'h1E}};

  always #25 ref_clk_i = ~ref_clk_i;

  always @(negedge ref_clk_i) bit_tick <= tick_en & ~bit_tick;

  always @(posedge ref_clk_i)
  begin
    if (ctl.rx_fifo_reset === 1'b1) n_rxr++;
    if (ctl.tx_fifo_reset === 1'b1) n_txr++;
    if (bit_tick) ticks++;
    if (rx_pop === 1'b1) n_pop++;
  end

  host_cpu_model i_host_cpu_model (
    .ref_clk_i(ref_clk_i),
    .host_o(host),
    .rdata_i(rdata)
  );

  uart_irq_fifo_format_ctl i_uart_irq_fifo_format_ctl (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .host_i(host),
    .rdata_o(rdata),
    .irq_o(irq),
    .rx_level_i(rx_level),
    .tx_level_i(tx_level),
    .rx_data_i(8'hA5),
    .line_state_i(line_state),
    .modem_state_i(modem_state),
    .rx_char_i(ev[3]),
    .bit_tick_i(bit_tick),
    .xoff_match_i(ev[0]),
    .xon_match_i(ev[1]),
    .spec_match_i(ev[2]),
    .rts_pin_n_i(rts_n),
    .cts_pin_n_i(cts_n),
    .ctl_o(ctl),
    .rx_pop_o(rx_pop),
    .tx_push_o(tx_push),
    .tx_data_o(tx_data),
    .tx_ready_pin_n_o(tx_pin_n),
    .rx_ready_pin_n_o(rx_pin_n)
  );

  // ****
  // helpers
  // ****
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // settle time lets a cleared source give way first
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    repeat (3) @(negedge ref_clk_i);
    i_host_cpu_model.rd(a, q);
    check(q, exp);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 300)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    if (irq !== lvl)
    begin
      failures++;
      tally_and_finish();
    end
  endtask

  task automatic pulse(input int b);
    @(negedge ref_clk_i);
    ev[b] = 1'b1;
    @(negedge ref_clk_i);
    ev[b] = 1'b0;
  endtask

  // ****
  // sequence
  // ****
  initial
  begin
    repeat (4) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    check(ctl.rx_trig, 8'h08);
    check({5'h00, ctl.stop_sel, ctl.char_len}, 8'h00);
    rdchk(`OFS_ISR, 8'h01);
    i_host_cpu_model.wr(`OFS_LCR, `LCR_EFR_KEY);
    i_host_cpu_model.wr(`OFS_ISR, 8'hD0);
    foreach (rows[i])
    begin
      i_host_cpu_model.wr(`OFS_LCR, rows[i].line_format);
      i_host_cpu_model.wr(`OFS_ISR, rows[i].fifo_setup);
      rdchk(`OFS_LCR, rows[i].line_format);
      check(ctl.rx_trig, rows[i].rx);
      check(ctl.tx_trig, rows[i].tx);
      check(ctl.dma_mode, rows[i].fifo_setup[3]);
      check({6'h00, tx_pin_n, rx_pin_n}, {6'h00, ~rows[i].fifo_setup[3], 1'b1});
      check({5'h00, ctl.stop_sel, ctl.char_len}, rows[i].line_format);
    end
    i_host_cpu_model.wr(`OFS_ISR, 8'h06);
    rdchk(`OFS_ISR, 8'h01);
    check(ctl.rx_trig, 8'h1E);
    check(n_rxr[7:0] | n_txr[7:0], 8'h00);
    i_host_cpu_model.wr(`OFS_ISR, 8'h07);
    i_host_cpu_model.wr(`OFS_ISR, 8'h01);
    rdchk(`OFS_ISR, 8'hC1);
    check(n_rxr[7:0], 8'h01);
    check(n_txr[7:0], 8'h01);
    i_host_cpu_model.wr(`OFS_IER, 8'hEF);
    line_state = 8'h02;
    modem_state = 8'h01;
    wait_irq(1'b1);
    rdchk(`OFS_ISR, 8'hC6);
    rdchk(`OFS_LSR, 8'h02);
    line_state = 8'h00;
    rdchk(`OFS_ISR, 8'hC0);
    rdchk(`OFS_MSR, 8'h01);
    modem_state = 8'h00;
    wait_irq(1'b0);
    rdchk(`OFS_ISR, 8'hC1);
    rx_level = 6'h08;
    wait_irq(1'b1);
    rdchk(`OFS_ISR, 8'hC4);
    check({6'h00, tx_pin_n, rx_pin_n}, 8'h02);
    rx_level = 6'h07;
    wait_irq(1'b0);
    ticks = 0;
    tick_en = 1'b1;
    wait_irq(1'b1);
    tick_en = 1'b0;
    check(8'(ticks >= 56 && ticks <= 58), 8'h01);
    rdchk(`OFS_ISR, 8'hCC);
    rdchk(`OFS_DATA, 8'hA5);
    check(n_pop[7:0], 8'h01);
    wait_irq(1'b0);
    rx_level = 6'h00;
    tx_level = 6'h04;
    wait_irq(1'b1);
    rdchk(`OFS_ISR, 8'hC2);
    wait_irq(1'b0);
    tx_level = 6'h14;
    i_host_cpu_model.wr(`OFS_DATA, 8'h3C);
    check(tx_push, 1'b1);
    check(tx_data, 8'h3C);
    @(negedge ref_clk_i);
    check(tx_push, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      if (k == 0) cts_n = 1'b1;
      else rts_n = 1'b1;
      wait_irq(1'b1);
      rdchk(`OFS_ISR, 8'hE0);
      rdchk(`OFS_MSR, 8'h00);
      wait_irq(1'b0);
    end
    pulse(0);
    wait_irq(1'b1);
    rdchk(`OFS_ISR, 8'hD0);
    wait_irq(1'b0);
    pulse(0);
    wait_irq(1'b1);
    pulse(1);
    wait_irq(1'b0);
    pulse(2);
    wait_irq(1'b1);
    pulse(3);
    wait_irq(1'b0);
    rdchk(`OFS_ISR, 8'hC1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
